// ==== design/tpc_device.sv ====
// Our own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ns
`include "tpc_defs.svh"
module tpc_device #(
   parameter int REF_DIV = `TPC_REF_DIV,
   parameter int PRESCALE = `TPC_PRESCALE
) (
   // clock and reset
   input wire logic mclk_in,
   input wire logic resetn_in,
   // two-wire bus
   tpc_if.dev bus,
   // synthesizer inputs
   input wire logic crystal_pin_a_in,
   input wire logic tuner_input_in,
   input wire tpc_pkg::tpc_addr_sel_t address_select_pin_in,
   // charge pump and drive
   output logic pump_up_out,
   output logic pump_down_out,
   output logic charge_pump_output_oe_out,
   output logic pump_high_current_out,
   output logic tuning_drive_output_en_out,
   // ports {general_output_b, general_output_a, band_switch_two..zero}
   output logic [4:0] port_active_out,
   output logic [14:0] divider_ratio_out
);
   import tpc_pkg::*;

   // a divide-by-one still needs a one-bit counter
   localparam int RW = (REF_DIV > 1) ? $clog2(REF_DIV) : 1;
   localparam int PW = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;

   logic [2:0] scl_s;
   logic [2:0] sda_s;
   logic [2:0] xtal_s;
   logic [2:0] vco_s;
   logic [1:0] asel_s1;
   logic [1:0] asel_s2;
   logic [1:0] chip_addr;
   tpc_dev_state_t state;
   logic [3:0] bit_cnt;
   logic [7:0] shift;
   logic ack_pend;
   logic sda_oe;
   logic pair_ctl;
   logic pair_second;
   logic [14:0] divider;
   logic pump_current;
   logic test_route;
   logic pump_tristate;
   logic drive_disable;
   logic [4:0] port_bits;
   logic [RW-1:0] ref_cnt;
   logic [PW-1:0] pre_cnt;
   logic [14:0] prog_cnt;
   logic up_q;
   logic dn_q;
   logic divided_input_test_signal;

   // first stage feeds only the second
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         scl_s <= 3'h7;
         sda_s <= 3'h7;
         xtal_s <= 3'h0;
         vco_s <= 3'h0;
         asel_s1 <= 2'h0;
         asel_s2 <= 2'h0;
      end else begin
         scl_s <= {scl_s[1:0], bus.scl};
         sda_s <= {sda_s[1:0], bus.sda};
         xtal_s <= {xtal_s[1:0], crystal_pin_a_in};
         vco_s <= {vco_s[1:0], tuner_input_in};
         asel_s1 <= address_select_pin_in;
         asel_s2 <= asel_s1;
      end
   end

   wire scl_rise = scl_s[1] & ~scl_s[2];
   wire scl_fall = ~scl_s[1] & scl_s[2];
   wire scl_high = scl_s[1] & scl_s[2];
   wire start_cond = scl_high & sda_s[2] & ~sda_s[1];
   wire stop_cond = scl_high & ~sda_s[2] & sda_s[1];
   wire [7:0] next_byte = {shift[6:0], sda_s[1]};
   wire byte_done = scl_rise & (bit_cnt == 4'h7) & (state == TPC_ADDR | state == TPC_DATA);
   wire addr_ok = (next_byte[7:3] == `TPC_ADDR_FIXED) & (next_byte[2:1] == chip_addr)
                  & ~next_byte[0];

   // pin level held static, decoded continuously
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         chip_addr <= 2'h0;
      end else begin
         unique case (tpc_addr_sel_t'(asel_s2))
            TPC_ASEL_LOW: chip_addr <= 2'h0;
            TPC_ASEL_OPEN: chip_addr <= 2'h1;
            TPC_ASEL_MID: chip_addr <= 2'h2;
            TPC_ASEL_HIGH: chip_addr <= 2'h3;
         endcase
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         state <= TPC_IDLE;
      end else if (start_cond) begin
         state <= TPC_ADDR;
      end else if (stop_cond) begin
         state <= TPC_IDLE;
      end else if (byte_done && state == TPC_ADDR) begin
         state <= addr_ok ? TPC_DATA : TPC_SKIP;
      end
   end

   // bits taken on rising clock only
   always_ff @(posedge mclk_in) begin
      if (!resetn_in || start_cond) begin
         bit_cnt <= 4'h0;
         shift <= 8'h00;
      end else if (scl_rise) begin
         shift <= next_byte;
         bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
      end
   end

   // pull low from the fall after bit 8 to the fall after bit 9
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         ack_pend <= 1'b0;
         sda_oe <= 1'b0;
      end else if (start_cond || stop_cond) begin
         ack_pend <= 1'b0;
         sda_oe <= 1'b0;
      end else if (byte_done) begin
         ack_pend <= (state == TPC_DATA) | addr_ok;
      end else if (scl_fall) begin
         sda_oe <= ack_pend;
         ack_pend <= 1'b0;
      end
   end
   assign bus.dev_sda_oe = sda_oe;

   // pair tracking restarts with every telegram
   always_ff @(posedge mclk_in) begin
      if (!resetn_in || start_cond) begin
         pair_ctl <= 1'b0;
         pair_second <= 1'b0;
      end else if (byte_done && state == TPC_DATA) begin
         if (!pair_second) begin
            pair_ctl <= next_byte[7];
         end
         pair_second <= ~pair_second;
      end
   end

   // values survive telegrams that do not rewrite them
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         divider <= `TPC_N_RESET;
         pump_current <= 1'b0;
         test_route <= 1'b0;
         pump_tristate <= 1'b0;
         drive_disable <= 1'b0;
         port_bits <= `TPC_PORT_RESET;
      end else if (byte_done && state == TPC_DATA) begin
         if (!pair_second && !next_byte[7]) begin
            divider[14:8] <= next_byte[6:0];
         end else if (!pair_second) begin
            pump_current <= next_byte[`TPC_LOOP_CURRENT];
            test_route <= next_byte[`TPC_LOOP_TEST];
            pump_tristate <= next_byte[`TPC_LOOP_TRI];
            drive_disable <= next_byte[`TPC_LOOP_DRVOFF];
         end else if (!pair_ctl) begin
            divider[7:0] <= next_byte;
         end else begin
            port_bits <= {next_byte[`TPC_PORT_GEN_B], next_byte[`TPC_PORT_GEN_A],
                          next_byte[`TPC_PORT_BAND_HI:0]};
         end
      end
   end

   wire xtal_tick = xtal_s[1] & ~xtal_s[2];
   wire vco_tick = vco_s[1] & ~vco_s[2];
   wire ref_evt = xtal_tick & (ref_cnt == RW'(REF_DIV - 1));
   wire pre_evt = vco_tick & (pre_cnt == PW'(PRESCALE - 1));
   // ratios below the legal floor run at the floor
   wire [14:0] n_eff = (divider < `TPC_N_MIN) ? `TPC_N_MIN : divider;
   wire div_evt = pre_evt & (prog_cnt >= n_eff - 15'h0001);

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         ref_cnt <= '0;
      end else if (xtal_tick) begin
         ref_cnt <= ref_evt ? '0 : ref_cnt + RW'(1);
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         pre_cnt <= '0;
         prog_cnt <= 15'h0000;
      end else if (vco_tick) begin
         pre_cnt <= pre_evt ? '0 : pre_cnt + PW'(1);
         if (pre_evt) begin
            prog_cnt <= div_evt ? 15'h0000 : prog_cnt + 15'h0001;
         end
      end
   end

   // the later edge cancels the earlier, so the gap is the pulse
   wire next_up = up_q | div_evt;
   wire next_dn = dn_q | ref_evt;
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         up_q <= 1'b0;
         dn_q <= 1'b0;
      end else begin
         up_q <= next_up & ~next_dn;
         dn_q <= next_dn & ~next_up;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         divided_input_test_signal <= 1'b0;
      end else if (div_evt) begin
         divided_input_test_signal <= ~divided_input_test_signal;
      end
   end

   // leakage off-chip may drift the tune voltage while floating
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         pump_up_out <= 1'b0;
         pump_down_out <= 1'b0;
         charge_pump_output_oe_out <= 1'b0;
         pump_high_current_out <= 1'b0;
         tuning_drive_output_en_out <= 1'b0;
         port_active_out <= 5'h00;
         divider_ratio_out <= 15'h0000;
      end else begin
         pump_up_out <= up_q & ~pump_tristate;
         pump_down_out <= dn_q & ~pump_tristate;
         charge_pump_output_oe_out <= (up_q | dn_q) & ~pump_tristate;
         pump_high_current_out <= pump_current;
         tuning_drive_output_en_out <= ~drive_disable;
         port_active_out <= {test_route ? divided_input_test_signal : port_bits[4],
                             port_bits[3:0]};
         divider_ratio_out <= divider;
      end
   end
endmodule // tpc_device

// ==== design/tpc_defs.svh ====
`ifndef TPC_DEFS_SVH
`define TPC_DEFS_SVH
// synthesizer dividers
`define TPC_REF_DIV 512
`define TPC_PRESCALE 8
`define TPC_N_MIN 15'h0100
`define TPC_N_MAX 15'h7FFF
// two-wire address
`define TPC_ADDR_FIXED 5'h18
// first control byte fields
`define TPC_LOOP_CURRENT 6
`define TPC_LOOP_TEST 5
`define TPC_LOOP_TRI 4
`define TPC_LOOP_DRVOFF 0
// second control byte fields
`define TPC_PORT_GEN_B 7
`define TPC_PORT_GEN_A 4
`define TPC_PORT_BAND_HI 2
// reset values
`define TPC_N_RESET 15'h0100
`define TPC_PORT_RESET 5'h00
// host command port
`define TPC_HOST_QTR 8
`define TPC_CMD_OFS 4'h0
`define TPC_STAT_OFS 4'h4
`define TPC_CMD_START 8
`define TPC_CMD_SEND 9
`define TPC_CMD_STOP 10
`define TPC_STAT_BUSY 0
`define TPC_STAT_ACK 1
`endif

// ==== design/tpc_pkg.sv ====
package tpc_pkg;
   typedef enum logic [3:0] {
      TPC_IDLE = 4'b0001,
      TPC_ADDR = 4'b0010,
      TPC_DATA = 4'b0100,
      TPC_SKIP = 4'b1000
   } tpc_dev_state_t;
   typedef enum logic [3:0] {
      TPC_H_IDLE = 4'b0001,
      TPC_H_START = 4'b0010,
      TPC_H_BYTE = 4'b0100,
      TPC_H_STOP = 4'b1000
   } tpc_host_state_t;
   typedef enum logic [1:0] {
      TPC_ASEL_LOW = 2'h0,
      TPC_ASEL_OPEN = 2'h1,
      TPC_ASEL_MID = 2'h2,
      TPC_ASEL_HIGH = 2'h3
   } tpc_addr_sel_t;
endpackage

// ==== design/tpc_if.sv ====
`timescale 1ns/1ns
interface tpc_if;
   // open-drain pull enables, high while pulling low
   logic host_scl_oe;
   logic host_sda_oe;
   logic dev_sda_oe;
   // resolved wire levels, pull-up gives the high level
   logic scl;
   logic sda;
   assign scl = ~host_scl_oe;
   assign sda = ~(host_sda_oe | dev_sda_oe);
   modport dev (input scl, input sda, output dev_sda_oe);
   modport host (input scl, input sda, output host_scl_oe, output host_sda_oe);
endinterface

// ==== design/tpc_host.sv ====
`timescale 1ns/1ns
`include "tpc_defs.svh"
module tpc_host #(
   parameter int QTR = `TPC_HOST_QTR
) (
   // clock and reset
   input wire logic mclk_in,
   input wire logic resetn_in,
   // wishbone slave
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [3:0] wb_adr_in,
   input wire logic [31:0] wb_dat_in,
   input wire logic [3:0] wb_sel_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   // two-wire bus
   tpc_if.host bus
);
   import tpc_pkg::*;

   localparam int QW = $clog2(QTR + 1);

   tpc_host_state_t state;
   logic [1:0] sda_s;
   logic [QW-1:0] qcnt;
   logic [1:0] phase;
   logic [3:0] bit_idx;
   logic [7:0] cmd_byte;
   logic [7:0] tx_sh;
   logic pend_start;
   logic pend_send;
   logic pend_stop;
   logic last_ack;
   logic scl_oe;
   logic sda_oe;

   wire busy = (state != TPC_H_IDLE) | pend_start | pend_send | pend_stop;
   wire wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
   // writes land on the edge where the master sees ack high
   wire wb_fin = wb_cyc_in & wb_stb_in & wb_ack_out;
   // commands while busy are dropped, software polls busy first
   wire cmd_wr = wb_fin & wb_we_in & (wb_adr_in == `TPC_CMD_OFS) & wb_sel_in[1] & ~busy;
   wire tick = (qcnt == QW'(QTR - 1));

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         sda_s <= 2'h3;
      end else begin
         sda_s <= {sda_s[0], bus.sda};
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h00000000;
      end else begin
         wb_ack_out <= wb_req;
         wb_dat_out <= 32'h00000000;
         if (wb_req && !wb_we_in && wb_adr_in == `TPC_STAT_OFS) begin
            wb_dat_out[`TPC_STAT_BUSY] <= busy;
            wb_dat_out[`TPC_STAT_ACK] <= last_ack;
         end else if (wb_req && !wb_we_in && wb_adr_in == `TPC_CMD_OFS) begin
            wb_dat_out[7:0] <= cmd_byte;
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         cmd_byte <= 8'h00;
      end else if (cmd_wr && wb_sel_in[0]) begin
         cmd_byte <= wb_dat_in[7:0];
      end
   end

   // quarter-bit divider, held at zero when idle to align phases
   always_ff @(posedge mclk_in) begin
      if (!resetn_in || state == TPC_H_IDLE || tick) begin
         qcnt <= '0;
      end else begin
         qcnt <= qcnt + QW'(1);
      end
   end

   // clock only ever pulled low, released for the high level
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         state <= TPC_H_IDLE;
         phase <= 2'h0;
         bit_idx <= 4'h0;
         tx_sh <= 8'h00;
         pend_start <= 1'b0;
         pend_send <= 1'b0;
         pend_stop <= 1'b0;
         last_ack <= 1'b0;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
      end else begin
         if (cmd_wr) begin
            pend_start <= wb_dat_in[`TPC_CMD_START];
            pend_send <= wb_dat_in[`TPC_CMD_SEND];
            pend_stop <= wb_dat_in[`TPC_CMD_STOP];
         end
         unique case (state)
            TPC_H_IDLE: begin
               phase <= 2'h0;
               if (pend_start) begin
                  pend_start <= 1'b0;
                  state <= TPC_H_START;
               end else if (pend_send) begin
                  pend_send <= 1'b0;
                  tx_sh <= cmd_byte;
                  bit_idx <= 4'h0;
                  state <= TPC_H_BYTE;
               end else if (pend_stop) begin
                  pend_stop <= 1'b0;
                  state <= TPC_H_STOP;
               end
            end
            TPC_H_START: begin
               if (tick) begin
                  phase <= phase + 2'h1;
                  case (phase)
                     2'h0: sda_oe <= 1'b0;
                     2'h1: scl_oe <= 1'b0;
                     2'h2: sda_oe <= 1'b1;
                     2'h3: begin
                        scl_oe <= 1'b1;
                        state <= TPC_H_IDLE;
                     end
                  endcase
               end
            end
            TPC_H_BYTE: begin
               if (tick) begin
                  phase <= phase + 2'h1;
                  case (phase)
                     2'h0: sda_oe <= ~tx_sh[7];
                     2'h1: scl_oe <= 1'b0;
                     2'h2: begin
                        if (bit_idx == 4'h8) begin
                           last_ack <= ~sda_s[1];
                        end
                     end
                     2'h3: begin
                        scl_oe <= 1'b1;
                        tx_sh <= {tx_sh[6:0], 1'b1};
                        bit_idx <= bit_idx + 4'h1;
                        if (bit_idx == 4'h8) begin
                           state <= TPC_H_IDLE;
                        end
                     end
                  endcase
               end
            end
            TPC_H_STOP: begin
               if (tick) begin
                  phase <= phase + 2'h1;
                  case (phase)
                     2'h0: sda_oe <= 1'b1;
                     2'h1: scl_oe <= 1'b0;
                     2'h2: sda_oe <= 1'b0;
                     2'h3: state <= TPC_H_IDLE;
                  endcase
               end
            end
         endcase
      end
   end

   assign bus.host_scl_oe = scl_oe;
   assign bus.host_sda_oe = sda_oe;
endmodule // tpc_host

// ==== dv/tpc_checker.sv ====
`timescale 1ns/1ns
`include "tpc_defs.svh"
module tpc_checker (
   // clock and reset
   input wire logic mclk_in,
   input wire logic resetn_in,
   // two-wire interface signals
   input wire logic host_scl_oe,
   input wire logic host_sda_oe,
   input wire logic dev_sda_oe,
   input wire logic scl,
   input wire logic sda
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);
   logic scl_d;
   logic sda_d;
   logic [3:0] rise_cnt;
   logic [7:0] shreg;
   logic first_byte;
   logic foreign;
   logic idle;
   logic start_ev;
   logic stop_ev;
   logic addr_good;
   assign addr_good = shreg[7:3] == `TPC_ADDR_FIXED && !shreg[0];
   assign start_ev = scl && scl_d && sda_d && !sda;
   assign stop_ev = scl && scl_d && !sda_d && sda;
   always_ff @(posedge mclk_in) begin
      scl_d <= scl;
      sda_d <= sda;
   end
   // counts rising clocks per byte, wraps after the ninth
   always_ff @(posedge mclk_in) begin
      if (!resetn_in || start_ev) begin
         rise_cnt <= 4'h0;
         first_byte <= 1'b1;
      end else if (scl && !scl_d) begin
         rise_cnt <= (rise_cnt == 4'h9) ? 4'h1 : rise_cnt + 4'h1;
         if (rise_cnt == 4'h9) begin
            first_byte <= 1'b0;
         end
      end
   end
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         shreg <= 8'h00;
      end else if (scl && !scl_d) begin
         shreg <= {shreg[6:0], sda};
      end
   end
   // foreign latch lives until the next start, repeated starts included
   always_ff @(posedge mclk_in) begin
      if (!resetn_in || start_ev) begin
         foreign <= 1'b0;
      end else if (first_byte && rise_cnt == 4'h8 && !addr_good) begin
         foreign <= 1'b1;
      end
   end
   always_ff @(posedge mclk_in) begin
      if (!resetn_in || stop_ev) begin
         idle <= 1'b1;
      end else if (start_ev) begin
         idle <= 1'b0;
      end
   end
   a_ack_after_eighth: assert property ($rose(dev_sda_oe) |-> rise_cnt == 4'h8 && !scl)
      else $error("acknowledge not after eighth clock");
   a_ack_own_addr: assert property ($rose(dev_sda_oe) && first_byte |-> addr_good)
      else $error("acknowledge of a wrong address byte");
   a_mute_foreign: assert property ($rose(dev_sda_oe) |-> !foreign)
      else $error("acknowledge after foreign address");
   a_ack_width: assert property ($rose(dev_sda_oe) |-> dev_sda_oe [*8])
      else $error("acknowledge too short");
   a_ack_release: assert property ($rose(dev_sda_oe) |-> ##[26:38] $fell(dev_sda_oe))
      else $error("acknowledge not released after ninth clock");
   a_sda_still_high: assert property (scl && scl_d |-> $stable(dev_sda_oe))
      else $error("device moved data while clock high");
   a_idle_no_pull: assert property (idle |-> !dev_sda_oe)
      else $error("device pulls data on idle bus");
   a_scl_host_only: assert property (scl == !host_scl_oe)
      else $error("clock line not owned by host alone");
   a_reset_free: assert property ($rose(resetn_in) |-> !dev_sda_oe && sda == !host_sda_oe)
      else $error("data line pulled at reset release");
   cover property ($rose(dev_sda_oe));
   cover property (stop_ev);
   cover property (foreign && scl && !scl_d);
endmodule // tpc_checker

// ==== dv/tpc_tb.sv ====
`timescale 1ns/1ns
module tpc_tb;
   import tpc_pkg::*;
   logic mclk;
   logic resetn;
   logic cyc, stb, we, ack, up, dn, poe, hic, drv;
   logic xtal = 1'b0;
   logic tuner = 1'b0;
   logic [3:0] adr, sel;
   logic [31:0] wdat, rdat;
   logic [4:0] port;
   logic [14:0] ratio;
   tpc_addr_sel_t asel;
   int bad_count = 0;
   int checks_done = 0;
   int xh = 8;
   int th = 3;
   int xc = 0;
   int tc = 0;
   logic [14:0] ntab [4] = '{15'h7FFF, 15'h0100, 15'h2A55, 15'h55AA};
   tpc_if bus ();
   tpc_host tpc_host_i (.mclk_in(mclk), .resetn_in(resetn), .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(wdat), .wb_sel_in(sel), .wb_dat_out(rdat),
      .wb_ack_out(ack), .bus(bus));
   // shortened dividers keep phase windows to a few thousand cycles
   tpc_device #(.REF_DIV(128), .PRESCALE(1)) tpc_device_i (.mclk_in(mclk), .resetn_in(resetn),
      .bus(bus), .crystal_pin_a_in(xtal), .tuner_input_in(tuner), .address_select_pin_in(asel),
      .pump_up_out(up), .pump_down_out(dn), .charge_pump_output_oe_out(poe),
      .pump_high_current_out(hic), .tuning_drive_output_en_out(drv), .port_active_out(port),
      .divider_ratio_out(ratio));
   tpc_checker tpc_checker_i (.mclk_in(mclk), .resetn_in(resetn),
      .host_scl_oe(bus.host_scl_oe), .host_sda_oe(bus.host_sda_oe),
      .dev_sda_oe(bus.dev_sda_oe), .scl(bus.scl), .sda(bus.sda));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // crystal and tuner squares, half periods in clock cycles
   always @(posedge mclk) begin
      if (xc >= xh - 1) begin
         xc <= 0;
         xtal <= ~xtal;
      end else begin
         xc <= xc + 1;
      end
      if (tc >= th - 1) begin
         tc <= 0;
         tuner <= ~tuner;
      end else begin
         tc <= tc + 1;
      end
   end
   task automatic fail(input string m);
      $display("[ERR] %0t %s", $time, m);
      bad_count++;
   endtask
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks_done++;
      if (got !== exp) begin
         fail(m);
      end
   endtask
   task automatic chk_cond(input logic c, input string m);
      checks_done++;
      if (c !== 1'b1) begin
         fail(m);
      end
   endtask
   task automatic stop_test();
      if (bad_count == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
         output logic [31:0] q);
      int n;
      n = 0;
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge mclk);
         n++;
      end while (ack !== 1'b1 && n < 100);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (n >= 100) begin
         fail("bus timeout");
         stop_test();
      end
   endtask
   // one command per byte: start on the first, stop on the last
   task automatic tg(input logic [7:0] bs[$], input int acks);
      logic [31:0] q;
      int n;
      foreach (bs[i]) begin
         wb(1'b1, 4'h0, {21'h0, i == bs.size() - 1, 1'b1, i == 0, bs[i]}, q);
         n = 0;
         do begin
            wb(1'b0, 4'h4, 32'h0, q);
            n++;
         end while (q[0] !== 1'b0 && n < 500);
         if (n >= 500) begin
            fail("busy timeout");
            stop_test();
         end
         chk_val({31'h0, q[1]}, {31'h0, i < acks}, "acknowledge");
      end
      chk_val({30'h0, bus.scl, bus.sda}, 32'h3, "bus not idle after stop");
   endtask
   task automatic watch(output int nu, output int nd, output int no, output int nt);
      logic p4;
      nu = 0;
      nd = 0;
      no = 0;
      nt = 0;
      repeat (4000) @(posedge mclk);
      p4 = port[4];
      repeat (6500) begin
         @(posedge mclk);
         nu += (up === 1'b1);
         nd += (dn === 1'b1);
         no += (poe === 1'b1);
         nt += (port[4] !== p4);
         p4 = port[4];
      end
   endtask
   initial begin
      logic [31:0] q;
      int nu, nd, no, nt;
      logic [7:0] bad [3] = '{8'hC2, 8'hC1, 8'h40};
      {cyc, stb, we, adr, wdat, resetn} = '0;
      sel = 4'hF;
      asel = TPC_ASEL_LOW;
      repeat (16) @(posedge mclk);
      chk_val({31'h0, bus.dev_sda_oe}, 32'h0, "data pulled in reset");
      resetn <= 1'b1;
      repeat (3) @(posedge mclk);
      chk_val({17'h0, ratio}, 32'h0100, "ratio reset");
      chk_val({25'h0, port, drv, hic}, 32'h2, "control reset");
      wb(1'b0, 4'h8, 32'h0, q);
      chk_val(q, 32'h0, "unmapped read");
      for (int k = 0; k < 3; k++) begin
         tg('{bad[k], 8'h12}, 0);
         chk_val({17'h0, ratio}, 32'h0100, "foreign write applied");
      end
      for (int k = 0; k < 4; k++) begin
         asel <= tpc_addr_sel_t'(k);
         repeat (8) @(posedge mclk);
         tg('{{5'h18, 2'(k), 1'b0}, {1'b0, ntab[k][14:8]}, ntab[k][7:0]}, 3);
         chk_val({17'h0, ratio}, {17'h0, ntab[k]}, "divider ratio");
      end
      wb(1'b0, 4'h0, 32'h0, q);
      chk_val({24'h0, q[7:0]}, 32'hAA, "command readback");
      // ignored control bits set on purpose, odd divider byte alone
      tg('{8'hC6, 8'hC3, 8'hFD, 8'h12}, 4);
      chk_val({17'h0, ratio}, 32'h12AA, "upper byte only");
      chk_val({25'h0, port, drv, hic}, 32'h75, "control fields");
      tg('{8'hC6, 8'h82, 8'h00, 8'h01, 8'h00}, 5);
      chk_val({25'h0, port, drv, hic}, 32'h2, "control cleared");
      watch(nu, nd, no, nt);
      chk_cond(nu > 0 && nu > 8 * nd && no > 0, "early divided edge");
      tg('{8'hC6, 8'h02, 8'h00}, 3);
      watch(nu, nd, no, nt);
      chk_cond(nd > 0 && nd > 8 * nu && no > 0, "late divided edge");
      tg('{8'hC6, 8'h92}, 2);
      watch(nu, nd, no, nt);
      chk_cond(nu == 0 && nd == 0 && no == 0, "pump not tristated");
      tg('{8'hC6, 8'hA2, 8'h09}, 3);
      watch(nu, nd, no, nt);
      chk_cond(nt >= 2 && port[3:0] === 4'h1, "test routing");
      resetn <= 1'b0;
      repeat (4) @(posedge mclk);
      resetn <= 1'b1;
      repeat (3) @(posedge mclk);
      chk_val({15'h0, ratio, bus.scl, bus.sda}, 32'h403, "second reset");
      stop_test();
   end
endmodule // tpc_tb
